// ### rtl/awc_defs.vh
// Register map, field positions, reset values and codes of the converter control block.
// Assumes an 8-bit register port; included by the control module.
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH

`define AWC_OFS_WINDOW_MODE   5'h04
`define AWC_OFS_SAMPLE_LEN    5'h05
`define AWC_OFS_POS_SEL       5'h08
`define AWC_OFS_NEG_SEL       5'h09
`define AWC_OFS_COMMAND       5'h0a
`define AWC_OFS_EVENT_CTL     5'h0b
`define AWC_OFS_CONV_CTL      5'h00
`define AWC_OFS_FLAGS         5'h0d
`define AWC_OFS_RESULT_L      5'h10
`define AWC_OFS_RESULT_H      5'h11
`define AWC_OFS_LOW_THR_L     5'h12
`define AWC_OFS_LOW_THR_H     5'h13
`define AWC_OFS_HIGH_THR_L    5'h14
`define AWC_OFS_HIGH_THR_H    5'h15

`define AWC_BIT_START         0
`define AWC_BIT_STOP          1
`define AWC_BIT_EVT_EN        0
`define AWC_BIT_CONTINUOUS_CONVERSION_BIT       1
`define AWC_BIT_WIN_FLAG      1

`define AWC_RST_BYTE          8'h00
`define AWC_RST_SEL           7'h00
`define AWC_RST_WORD          16'h0000

`define AWC_WIN_NONE          3'h0
`define AWC_WIN_BELOW         3'h1
`define AWC_WIN_ABOVE         3'h2
`define AWC_WIN_INSIDE        3'h3
`define AWC_WIN_OUTSIDE       3'h4

`define AWC_SAMPLE_BASE       9'h002
`define AWC_CONVERT_CYCLES    5'h0c

`endif

// ### rtl/awc_ctrl.v
// Command, sampling, input-select and window-compare control of the converter.
// Assumes the analog core returns a result word on result_in at conversion end.
`timescale 1ns/10ps
`include "awc_defs.vh"

module awc_ctrl #(
    parameter CONV_CYCLES = 12
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset_n,
    // Register port
    input  wire [4:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Analog core
    input  wire        event_in,
    input  wire [15:0] result_in,
    output reg  [6:0]  pos_sel_q,
    output reg  [6:0]  neg_sel_q,
    output reg         pos_valid_q,
    output reg         neg_valid_q,
    output reg         sampling_q,
    output reg         converting_q,
    output reg         conv_done_q,
    output reg         window_match_flag_q
);

localparam ST_IDLE   = 3'b001;
localparam ST_SAMPLE = 3'b010;
localparam ST_CONV   = 3'b100;

reg [2:0]  state_q;
reg [8:0]  count_q;
reg [2:0]  window_mode_field_q;
reg [7:0]  sample_length_field_q;
reg [6:0]  pos_pend_q;
reg [6:0]  neg_pend_q;
reg        pend_start_q;
reg        event_start_enable_q;
reg        continuous_conversion_bit_q;
reg        event_prev_q;
reg [15:0] result_q;
reg [15:0] low_threshold_q;
reg [15:0] high_threshold_q;

////////////////////////////////////////////////////////////////////////
function window_hit;
    input [2:0]  mode;
    input [15:0] res;
    input [15:0] lo;
    input [15:0] hi;
    begin
        case (mode)
            `AWC_WIN_BELOW:   window_hit = res < lo;
            `AWC_WIN_ABOVE:   window_hit = res > hi;
            `AWC_WIN_INSIDE:  window_hit = (res >= lo) && (res <= hi);
            `AWC_WIN_OUTSIDE: window_hit = (res < lo) || (res > hi);
            default:          window_hit = 1'b0;
        endcase
    end
endfunction

function pos_code_ok;
    input [6:0] c;
    begin
        pos_code_ok = (c <= 7'h15) || (c == 7'h40) || (c == 7'h42) || (c == 7'h44)
                   || (c == 7'h45) || ((c >= 7'h48) && (c <= 7'h4b));
    end
endfunction

function neg_code_ok;
    input [6:0] c;
    begin
        neg_code_ok = (c <= 7'h0f) || (c == 7'h40) || (c == 7'h48);
    end
endfunction

////////////////////////////////////////////////////////////////////////
wire busy       = (state_q != ST_IDLE);
wire wr_cmd     = reg_wr && (reg_addr == `AWC_OFS_COMMAND);
wire stop_req   = wr_cmd && reg_wdata[`AWC_BIT_STOP];
wire start_wr   = wr_cmd && reg_wdata[`AWC_BIT_START] && !reg_wdata[`AWC_BIT_STOP];
wire event_rise = event_start_enable_q && event_in && !event_prev_q;
wire conv_end   = (state_q == ST_CONV) && (count_q == 9'h001) && !stop_req;
wire rd_result  = reg_rd && ((reg_addr == `AWC_OFS_RESULT_L) || (reg_addr == `AWC_OFS_RESULT_H));
wire flag_set   = conv_end && window_hit(window_mode_field_q, result_in,
                                         low_threshold_q, high_threshold_q);
wire flag_clr   = rd_result || (reg_wr && (reg_addr == `AWC_OFS_FLAGS)
                                && reg_wdata[`AWC_BIT_WIN_FLAG]);
// A queued start, a start write or an event edge fires when the engine is idle
wire launch     = !busy && !stop_req && (pend_start_q || start_wr || event_rise);

////////////////////////////////////////////////////////////////////////
// Conversion sequencer
always @(posedge clk_sys) begin
    if (!reset_n) begin
        state_q      <= ST_IDLE;
        count_q      <= 9'h000;
        pend_start_q <= 1'b0;
        result_q     <= `AWC_RST_WORD;
        conv_done_q  <= 1'b0;
        sampling_q   <= 1'b0;
        converting_q <= 1'b0;
        event_prev_q <= 1'b0;
    end else begin
        event_prev_q <= event_in;
        conv_done_q  <= conv_end;
        if (stop_req) begin
            state_q      <= ST_IDLE;
            pend_start_q <= 1'b0;
            sampling_q   <= 1'b0;
            converting_q <= 1'b0;
        end else begin
            // Start while busy is remembered until the engine frees up
            if ((start_wr || event_rise) && busy)
                pend_start_q <= 1'b1;
            case (state_q)
                ST_IDLE: begin
                    if (launch) begin
                        pend_start_q <= 1'b0;
                        state_q      <= ST_SAMPLE;
                        // Base sampling plus extension
                        count_q      <= `AWC_SAMPLE_BASE + {1'b0, sample_length_field_q};
                        sampling_q   <= 1'b1;
                        converting_q <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (count_q == 9'h001) begin
                        state_q    <= ST_CONV;
                        count_q    <= CONV_CYCLES[8:0];
                        sampling_q <= 1'b0;
                    end else begin
                        count_q <= count_q - 9'h001;
                    end
                end
                ST_CONV: begin
                    if (count_q == 9'h001) begin
                        result_q <= result_in;
                        // Free-running chains the next one without software help
                        if (continuous_conversion_bit_q) begin
                            state_q    <= ST_SAMPLE;
                            count_q    <= `AWC_SAMPLE_BASE + {1'b0, sample_length_field_q};
                            sampling_q <= 1'b1;
                        end else begin
                            state_q      <= ST_IDLE;
                            converting_q <= 1'b0;
                        end
                    end else begin
                        count_q <= count_q - 9'h001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Window flag: set wins over a clear in the same cycle
always @(posedge clk_sys) begin
    if (!reset_n)
        window_match_flag_q <= 1'b0;
    else if (flag_set)
        window_match_flag_q <= 1'b1;
    else if (flag_clr)
        window_match_flag_q <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// Control registers and input selects
always @(posedge clk_sys) begin
    if (!reset_n) begin
        window_mode_field_q         <= 3'h0;
        sample_length_field_q       <= `AWC_RST_BYTE;
        event_start_enable_q        <= 1'b0;
        continuous_conversion_bit_q <= 1'b0;
        low_threshold_q             <= `AWC_RST_WORD;
        high_threshold_q            <= `AWC_RST_WORD;
        pos_pend_q                  <= `AWC_RST_SEL;
        neg_pend_q                  <= `AWC_RST_SEL;
        pos_sel_q                   <= `AWC_RST_SEL;
        neg_sel_q                   <= `AWC_RST_SEL;
        pos_valid_q                 <= 1'b1;
        neg_valid_q                 <= 1'b1;
    end else begin
        if (reg_wr) begin
            case (reg_addr)
                `AWC_OFS_WINDOW_MODE: window_mode_field_q   <= reg_wdata[2:0];
                `AWC_OFS_SAMPLE_LEN:  sample_length_field_q <= reg_wdata;
                `AWC_OFS_POS_SEL:     pos_pend_q            <= reg_wdata[6:0];
                `AWC_OFS_NEG_SEL:     neg_pend_q            <= reg_wdata[6:0];
                `AWC_OFS_EVENT_CTL:   event_start_enable_q  <= reg_wdata[`AWC_BIT_EVT_EN];
                `AWC_OFS_CONV_CTL:
                    continuous_conversion_bit_q <= reg_wdata[`AWC_BIT_CONTINUOUS_CONVERSION_BIT];
                `AWC_OFS_LOW_THR_L:   low_threshold_q[7:0]   <= reg_wdata;
                `AWC_OFS_LOW_THR_H:   low_threshold_q[15:8]  <= reg_wdata;
                `AWC_OFS_HIGH_THR_L:  high_threshold_q[7:0]  <= reg_wdata;
                `AWC_OFS_HIGH_THR_H:  high_threshold_q[15:8] <= reg_wdata;
                default: begin
                end
            endcase
        end
        // Selects reach the analog mux only between conversions
        if (!converting_q) begin
            pos_sel_q   <= pos_pend_q;
            neg_sel_q   <= neg_pend_q;
            pos_valid_q <= pos_code_ok(pos_pend_q);
            neg_valid_q <= neg_code_ok(neg_pend_q);
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read port: data one cycle after the strobe, zero elsewhere
always @(posedge clk_sys) begin
    if (!reset_n) begin
        reg_rdata <= `AWC_RST_BYTE;
    end else if (reg_rd) begin
        case (reg_addr)
            `AWC_OFS_WINDOW_MODE: reg_rdata <= {5'h00, window_mode_field_q};
            `AWC_OFS_SAMPLE_LEN:  reg_rdata <= sample_length_field_q;
            `AWC_OFS_POS_SEL:     reg_rdata <= {1'b0, pos_pend_q};
            `AWC_OFS_NEG_SEL:     reg_rdata <= {1'b0, neg_pend_q};
            `AWC_OFS_COMMAND:     reg_rdata <= {7'h00, converting_q};
            `AWC_OFS_EVENT_CTL:   reg_rdata <= {7'h00, event_start_enable_q};
            `AWC_OFS_CONV_CTL:    reg_rdata <= {6'h00, continuous_conversion_bit_q, 1'b0};
            `AWC_OFS_FLAGS:       reg_rdata <= {6'h00, window_match_flag_q, 1'b0};
            `AWC_OFS_RESULT_L:    reg_rdata <= result_q[7:0];
            `AWC_OFS_RESULT_H:    reg_rdata <= result_q[15:8];
            `AWC_OFS_LOW_THR_L:   reg_rdata <= low_threshold_q[7:0];
            `AWC_OFS_LOW_THR_H:   reg_rdata <= low_threshold_q[15:8];
            `AWC_OFS_HIGH_THR_L:  reg_rdata <= high_threshold_q[7:0];
            `AWC_OFS_HIGH_THR_H:  reg_rdata <= high_threshold_q[15:8];
            default:              reg_rdata <= `AWC_RST_BYTE;
        endcase
    end else begin
        reg_rdata <= `AWC_RST_BYTE;
    end
end

endmodule

// ### dv/awc_ctrl_asserts.sv
// Port-level checks of the converter control block.
// Bound to awc_ctrl below; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module awc_ctrl_asserts #(parameter CONV_CYCLES = 12) (
    // Clock and reset
    input wire        clk_sys,
    input wire        reset_n,
    // Register port
    input wire [4:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // Analog core
    input wire        event_in,
    input wire [15:0] result_in,
    input wire [6:0]  pos_sel_q,
    input wire [6:0]  neg_sel_q,
    input wire        pos_valid_q,
    input wire        neg_valid_q,
    input wire        sampling_q,
    input wire        converting_q,
    input wire        conv_done_q,
    input wire        window_match_flag_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    reg  [7:0] conv_q;
    wire       cmd_wr  = reg_wr && reg_addr == 5'h0a;
    wire       stop_wr = cmd_wr && reg_wdata[1];
    // Convert-phase length, read back at the falling edge of a conversion
    always @(posedge clk_sys)
        conv_q <= (converting_q && !sampling_q) ? conv_q + 8'h01 : 8'h00;
    sequence s_start; cmd_wr && reg_wdata[1:0] == 2'b01 && !converting_q; endsequence
    // A stop also ends a conversion, but without a result
    sequence s_end; $fell(converting_q) && !$past(stop_wr); endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_POS_CODE: assert property (pos_valid_q ==
        (pos_sel_q inside {[7'h00:7'h15], 7'h40, 7'h42, 7'h44, 7'h45, [7'h48:7'h4b]}))
        else $error("bad positive valid");
    AST_NEG_CODE: assert property (neg_valid_q ==
        (neg_sel_q inside {[7'h00:7'h0f], 7'h40, 7'h48})) else $error("bad negative valid");
    AST_CONV_LEN: assert property (s_end |-> conv_q == CONV_CYCLES)
        else $error("bad conversion length");
    AST_DONE: assert property (s_end |-> conv_done_q)
        else $error("no done pulse");
    AST_STOP: assert property (stop_wr |=> !converting_q [*2])
        else $error("stop ignored");
    AST_START: assert property (s_start |=> converting_q && sampling_q)
        else $error("start ignored");
    AST_FLAG_END: assert property ($rose(window_match_flag_q) |-> conv_done_q)
        else $error("flag set outside conversion end");
    AST_FLAG_CLR: assert property (reg_rd && reg_addr[4:1] == 4'h8 |=>
        !window_match_flag_q || conv_done_q) else $error("flag kept after result read");
    AST_MUX_HOLD: assert property (converting_q && $past(converting_q) |->
        $stable(pos_sel_q) && $stable(neg_sel_q)) else $error("select moved in conversion");
endmodule

bind awc_ctrl awc_ctrl_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_awc_ctrl_asserts (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
    .result_in(result_in), .pos_sel_q(pos_sel_q), .neg_sel_q(neg_sel_q),
    .pos_valid_q(pos_valid_q), .neg_valid_q(neg_valid_q), .sampling_q(sampling_q),
    .converting_q(converting_q), .conv_done_q(conv_done_q),
    .window_match_flag_q(window_match_flag_q));

// ### dv/tb_top.sv
// Self-checking bench of the converter control block through its register port.
// Assumes one 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/10ps
`define chk(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module tb_top;
    reg         clk_sys   = 1'b0;
    reg         reset_n   = 1'b0;
    reg  [4:0]  reg_addr  = 5'h00;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr    = 1'b0;
    reg         reg_rd    = 1'b0;
    reg         event_in  = 1'b0;
    reg  [15:0] result_in = 16'h0000;
    reg         ef;
    wire [7:0]  reg_rdata;
    wire [6:0]  pos_sel_q, neg_sel_q;
    wire        pos_valid_q, neg_valid_q, sampling_q, converting_q, conv_done_q;
    wire        window_match_flag_q;
    integer     fails = 0;
    integer     tests_run = 0;
    integer     n, k, m, i;
    awc_ctrl #(.CONV_CYCLES(12)) u_awc_ctrl (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
        .result_in(result_in), .pos_sel_q(pos_sel_q), .neg_sel_q(neg_sel_q),
        .pos_valid_q(pos_valid_q), .neg_valid_q(neg_valid_q), .sampling_q(sampling_q),
        .converting_q(converting_q), .conv_done_q(conv_done_q),
        .window_match_flag_q(window_match_flag_q));
    initial forever #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task wr(input [4:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input [4:0] a, input [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `chk(reg_rdata, e)
    endtask
    // Cycles to the done pulse, counted from the last edge a task ended on
    task wait_done;
        n = 0;
        do begin
            tick;
            n++;
        end while (conv_done_q !== 1'b1 && n < 600);
        if (n >= 600) begin
            fails++;
            finish_test;
        end
    endtask
    // n counts done pulses, k busy cycles
    task watch(input integer c);
        n = 0;
        k = 0;
        repeat (c) begin
            tick;
            n = n + (conv_done_q === 1'b1);
            k = k + (converting_q === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (i = 0; i < 32; i++)
            rd(i[4:0], 8'h00);
        wr(5'h13, 8'h10);
        wr(5'h15, 8'h20);
        for (m = 0; m < 8; m++) begin
            for (i = 0; i < 4; i++) begin
                @(posedge clk_sys);
                result_in <= (i < 2) ? 16'h0fff + i[15:0] : 16'h1ffe + i[15:0];
                wr(5'h04, m[7:0]);
                wr(5'h0a, 8'h01);
                wait_done;
                ef = (m == 1 && i == 0) || (m == 2 && i == 3);
                ef = ef || (m == 3 && (i == 1 || i == 2)) || (m == 4 && (i == 0 || i == 3));
                `chk(window_match_flag_q, ef)
                rd(5'h11, result_in[15:8]);
                `chk(window_match_flag_q, 1'b0)
            end
        end
        wr(5'h04, 8'h04);
        wr(5'h0a, 8'h01);
        wait_done;
        `chk(window_match_flag_q, 1'b1)
        wr(5'h0d, 8'h02);
        #1 `chk(window_match_flag_q, 1'b0)
        wr(5'h04, 8'h00);
        for (m = 0; m < 3; m++) begin
            wr(5'h05, (m == 2) ? 8'hff : m[7:0]);
            wr(5'h0a, 8'h01);
            wait_done;
            `chk(n, (m == 2) ? 269 : 14 + m)
        end
        wr(5'h05, 8'h00);
        wr(5'h0a, 8'h01);
        rd(5'h0a, 8'h01);
        wr(5'h08, 8'h15);
        wr(5'h09, 8'h48);
        #1 `chk(pos_sel_q, 7'h00)
        rd(5'h08, 8'h15);
        wait_done;
        // Held selects reach the mux one cycle after the conversion ends
        tick;
        `chk(pos_sel_q, 7'h15)
        `chk(neg_sel_q, 7'h48)
        rd(5'h0a, 8'h00);
        for (i = 0; i < 128; i++) begin
            wr(5'h08, i[7:0]);
            wr(5'h09, i[7:0]);
            tick;
            ef = i[6:0] inside {[7'h00:7'h15], 7'h40, 7'h42, 7'h44, 7'h45, [7'h48:7'h4b]};
            `chk(pos_valid_q, ef)
            `chk(neg_valid_q, i[6:0] inside {[7'h00:7'h0f], 7'h40, 7'h48})
            `chk(neg_sel_q, i[6:0])
        end
        wr(5'h0a, 8'h01);
        wr(5'h0a, 8'h03);
        #1 `chk(converting_q, 1'b0)
        watch(30);
        `chk(k, 0)
        wr(5'h0a, 8'h01);
        wr(5'h0a, 8'h00);
        wait_done;
        `chk(n, 12)
        wr(5'h0a, 8'h01);
        wr(5'h0a, 8'h01);
        watch(60);
        `chk(n, 2)
        wr(5'h00, 8'h02);
        wr(5'h0a, 8'h01);
        watch(100);
        `chk(n > 5, 1'b1)
        wr(5'h0a, 8'h02);
        wr(5'h00, 8'h00);
        watch(30);
        `chk(k, 0)
        @(posedge clk_sys);
        event_in <= 1'b1;
        watch(30);
        `chk(k, 0)
        wr(5'h0b, 8'h01);
        event_in <= 1'b0;
        @(posedge clk_sys);
        event_in <= 1'b1;
        wait_done;
        `chk(n < 30, 1'b1)
        watch(30);
        `chk(k, 0)
        finish_test;
    end
endmodule
